// File: cct_pkg.sv
// Shared constants and types for the configuration control and test port block
// Assumes a 10 MHz system clock and a separate, free-standing test clock
package cct_pkg;
	localparam int unsigned CLK_SYS_HZ = 10_000_000;
	localparam int unsigned CRESET_MIN_NS = 320;
	localparam int unsigned CRESET_MIN_CYC =
		(CRESET_MIN_NS * (CLK_SYS_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned LOAD_CYC_DEF = 64;
	localparam int unsigned USER_HOLD_NS = 25_000;
	localparam int unsigned USER_HOLD_CYC = USER_HOLD_NS * (CLK_SYS_HZ / 1_000_000) / 1000;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned IR_W = 4;
	localparam int unsigned STAT_W = 2;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
	localparam logic [IR_W-1:0] IR_STATUS = 4'h2;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] IR_RESET_VAL = 4'hf;

	typedef enum logic [1:0] {
		CFG_LOAD = 2'b00,
		CFG_WAIT = 2'b01,
		CFG_USER = 2'b10
	} cct_cfg_st_t;

	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SH_DR = 4'h4,
		TAP_EX1_DR = 4'h5,
		TAP_PA_DR = 4'h6,
		TAP_EX2_DR = 4'h7,
		TAP_UP_DR = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'ha,
		TAP_SH_IR = 4'hb,
		TAP_EX1_IR = 4'hc,
		TAP_PA_IR = 4'hd,
		TAP_EX2_IR = 4'he,
		TAP_UP_IR = 4'hf
	} cct_tap_st_t;
endpackage : cct_pkg

// File: cct_stat_if.sv
// Status levels passed from the system domain to the test port
// Assumes the receiver synchronises every bit to its own clock
interface cct_stat_if
	import cct_pkg::*;
	();
	logic [STAT_W-1:0] status;
	modport sys (output status);
	modport tap (input status);
endinterface : cct_stat_if

// File: cct_tap.sv
// Boundary-scan test access port on the test clock
// Assumes board pull-ups on mode-select and serial input
module cct_tap
	import cct_pkg::*;
	(
	input wire logic tck,
	input wire logic rstn,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe,
	cct_stat_if.tap stat
);
	typedef struct packed {
		cct_tap_st_t st;
		logic [IR_W-1:0] ir;
		logic [IR_W-1:0] ir_sh;
		logic byp;
		logic [STAT_W-1:0] stat_sh;
		logic [STAT_W-1:0] s1;
		logic [STAT_W-1:0] s2;
	} cct_tap_t;

	cct_tap_t r_q, r_d;
	logic tdo_q, tdo_oe_q;
	logic shifting;

	assign shifting = (r_q.st == TAP_SH_DR) || (r_q.st == TAP_SH_IR);

	always_comb begin
		r_d = r_q;
		r_d.s1 = stat.status;
		r_d.s2 = r_q.s1;
		unique case (r_q.st)
			TAP_RESET: r_d.st = tms_i ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: r_d.st = tms_i ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: r_d.st = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: r_d.st = tms_i ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: r_d.st = tms_i ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: r_d.st = tms_i ? TAP_UP_DR : TAP_PA_DR;
			TAP_PA_DR: r_d.st = tms_i ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: r_d.st = tms_i ? TAP_UP_DR : TAP_SH_DR;
			TAP_UP_DR: r_d.st = tms_i ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: r_d.st = tms_i ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: r_d.st = tms_i ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: r_d.st = tms_i ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: r_d.st = tms_i ? TAP_UP_IR : TAP_PA_IR;
			TAP_PA_IR: r_d.st = tms_i ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: r_d.st = tms_i ? TAP_UP_IR : TAP_SH_IR;
			TAP_UP_IR: r_d.st = tms_i ? TAP_SEL_DR : TAP_IDLE;
		endcase
		unique case (r_q.st)
			TAP_RESET: r_d.ir = IR_RESET_VAL;
			TAP_CAP_IR: r_d.ir_sh = IR_CAPTURE;
			TAP_SH_IR: r_d.ir_sh = {tdi_i, r_q.ir_sh[IR_W-1:1]};
			TAP_UP_IR: r_d.ir = r_q.ir_sh;
			TAP_CAP_DR: begin
				r_d.byp = 1'b0;
				r_d.stat_sh = r_q.s2;
			end
			TAP_SH_DR: begin
				if (r_q.ir == IR_STATUS) begin
					r_d.stat_sh = {tdi_i, r_q.stat_sh[STAT_W-1:1]};
				end else begin
					r_d.byp = tdi_i;
				end
			end
			default: r_d.ir = r_q.ir;
		endcase
	end

	// Inputs sampled on the rising edge
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			r_q <= '{st: TAP_RESET, ir: IR_RESET_VAL, ir_sh: '1, byp: 1'b1,
				stat_sh: '0, s1: '0, s2: '0};
		end else begin
			r_q <= r_d;
		end
	end

	// Output changes after the falling edge only
	always_ff @(negedge tck or negedge rstn) begin
		if (!rstn) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_oe_q <= shifting;
			if (r_q.st == TAP_SH_IR) begin
				tdo_q <= r_q.ir_sh[0];
			end else if (r_q.ir == IR_STATUS) begin
				tdo_q <= r_q.stat_sh[0];
			end else begin
				tdo_q <= r_q.byp;
			end
		end
	end

	assign tdo_o = tdo_q;
	assign tdo_oe = tdo_oe_q;

	a_tdo_hiz_idle: assert property (@(posedge tck) disable iff (!rstn)
		tdo_oe == shifting) else $error("tdo enable does not match shift state");
	a_tms_reset: assert property (@(posedge tck) disable iff (!rstn)
		tms_i [*5] |=> r_q.st == TAP_RESET) else $error("five tms highs did not reset");
	a_ir_update: assert property (@(posedge tck) disable iff (!rstn)
		r_q.st == TAP_UP_IR |=> r_q.ir == $past(r_q.ir_sh)) else $error("ir not updated");
	a_bypass_delay: assert property (@(posedge tck) disable iff (!rstn)
		(r_q.st == TAP_SH_DR && r_q.ir == IR_BYPASS && !tms_i) |=> r_q.byp == $past(tdi_i))
		else $error("bypass path length wrong");
	c_ir_shift: cover property (@(posedge tck) disable iff (!rstn) r_q.st == TAP_UP_IR);
	c_status_read: cover property (@(posedge tck) disable iff (!rstn)
		r_q.st == TAP_SH_DR && r_q.ir == IR_STATUS);
endmodule : cct_tap

// File: cct_top.sv
// Configuration control pins: done flag, reconfig request and test port
// Assumes an external pull-up on the done pin and an asynchronous reconfig pin
module cct_top
	import cct_pkg::*;
	#(
	parameter int unsigned LOAD_CYC = LOAD_CYC_DEF
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic creset_req_n,
	input wire logic config_done_flag_i,
	output logic config_done_flag_o,
	output logic config_done_flag_oe,
	output logic user_mode,
	output logic reload_start,
	input wire logic tck,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe
);
	typedef struct packed {
		cct_cfg_st_t st;
		logic [1:0] req_sync;
		logic [1:0] done_sync;
		logic req_prev;
		logic [CNT_W-1:0] low_cnt;
		logic [CNT_W-1:0] load_cnt;
		logic done_oe;
		logic user;
		logic start;
	} cct_cfg_t;

	cct_cfg_t r_q, r_d;
	logic req_rise;
	logic pulse_ok;

	cct_stat_if stat_if ();

	assign req_rise = r_q.req_sync[1] && !r_q.req_prev;
	assign pulse_ok = r_q.low_cnt >= CNT_W'(CRESET_MIN_CYC);

	always_comb begin
		r_d = r_q;
		r_d.req_sync = {r_q.req_sync[0], creset_req_n};
		r_d.done_sync = {r_q.done_sync[0], config_done_flag_i};
		r_d.req_prev = r_q.req_sync[1];
		r_d.start = 1'b0;
		if (!r_q.req_sync[1]) begin
			if (r_q.low_cnt != '1) begin
				r_d.low_cnt = r_q.low_cnt + CNT_W'(1);
			end
		end else begin
			r_d.low_cnt = '0;
		end
		unique case (r_q.st)
			CFG_LOAD: begin
				if (r_q.load_cnt == CNT_W'(LOAD_CYC - 1)) begin
					r_d.st = CFG_WAIT;
				end else begin
					r_d.load_cnt = r_q.load_cnt + CNT_W'(1);
				end
			end
			CFG_WAIT: begin
				if (r_q.done_sync[1]) begin
					r_d.st = CFG_USER;
				end
			end
			CFG_USER: begin
				if (!r_q.done_sync[1]) begin
					r_d.st = CFG_WAIT;
				end
			end
			default: r_d.st = CFG_LOAD;
		endcase
		// Only the loader restarts, which also clears user mode; nothing else is cleared
		if (req_rise && pulse_ok) begin
			r_d.st = CFG_LOAD;
			r_d.load_cnt = '0;
			r_d.start = 1'b1;
		end
		r_d.done_oe = (r_d.st == CFG_LOAD);
		r_d.user = (r_d.st == CFG_USER);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			r_q <= '{st: CFG_LOAD, req_sync: 2'h3, done_sync: 2'h0, req_prev: 1'b1,
				low_cnt: '0, load_cnt: '0, done_oe: 1'b1, user: 1'b0, start: 1'b0};
		end else begin
			r_q <= r_d;
		end
	end

	// Pins are fixed in function, no general-purpose path exists
	assign config_done_flag_o = 1'b0;
	assign config_done_flag_oe = r_q.done_oe;
	assign user_mode = r_q.user;
	assign reload_start = r_q.start;
	assign stat_if.status = {r_q.user, r_q.done_oe};

	cct_tap u_tap (
		.tck(tck),
		.rstn(rstn),
		.tms_i(tms_i),
		.tdi_i(tdi_i),
		.tdo_o(tdo_o),
		.tdo_oe(tdo_oe),
		.stat(stat_if.tap)
	);

	a_done_open: assert property (@(posedge clk_sys) disable iff (!rstn)
		(r_q.st == CFG_LOAD) |-> config_done_flag_oe && !config_done_flag_o)
		else $error("done pin not pulled low while loading");
	a_held_low: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!r_q.done_sync[1] && !user_mode) |=> !user_mode)
		else $error("user mode entered while done pin held low");
	a_short_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
		reload_start |-> $past(r_q.low_cnt) >= CNT_W'(CRESET_MIN_CYC))
		else $error("reload after too short a pulse");
	a_reload_only: assert property (@(posedge clk_sys) disable iff (!rstn)
		reload_start |-> r_q.st == CFG_LOAD && !user_mode && r_q.load_cnt == '0)
		else $error("reload did not restart loader");
	a_load_end: assert property (@(posedge clk_sys) disable iff (!rstn)
		(r_q.st == CFG_LOAD && r_q.load_cnt == CNT_W'(LOAD_CYC - 1) && !r_d.start)
		|=> !config_done_flag_oe) else $error("done pin not released after load");
	c_reload: cover property (@(posedge clk_sys) disable iff (!rstn) reload_start);
	c_user: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(user_mode));
endmodule : cct_top

// File: cct_host.sv
// Far-side model: done pin pull-up, board hold-low and test controller
// Assumes the device drives done as open drain and tdo on falling tck
module cct_host
	import cct_pkg::*;
	(
	input wire logic done_o,
	input wire logic done_oe,
	input wire logic hold_low,
	input wire logic tdo_o,
	input wire logic tdo_oe,
	output logic done_wire,
	output logic tck,
	output logic tms,
	output logic tdi
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-up unless device or board pulls low
	assign done_wire = (done_oe && !done_o) || hold_low ? 1'b0 : 1'b1;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One test clock period; clock rests low between frames
	task automatic step(input logic m, input logic d, input logic drv,
		output logic q, output logic oe);
		#23;
		tms = drv ? m : 1'b1;
		tdi = drv ? d : 1'b1;
		#57;
		tck = 1'b1;
		// Released tdo reads as its weak pull-up
		q = tdo_oe ? tdo_o : 1'b1;
		oe = tdo_oe;
		#80;
		tck = 1'b0;
	endtask : step
endmodule : cct_host

// File: tb.sv
// Testbench: boot, done hold-low, reconfig pulses and test port shifts
// Assumes cct_host models the pull-ups and the test controller
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cct_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic creset_req_n = 1'b1;
	logic hold_low = 1'b0;
	logic done_wire, done_o, done_oe, user_mode, reload_start;
	logic tck, tms, tdi, tdo_o, tdo_oe, b, oe;
	logic [7:0] q;
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	always #50 clk_sys = ~clk_sys;
	cct_top #(.LOAD_CYC(40)) dut (.clk_sys(clk_sys), .rstn(rstn), .creset_req_n(creset_req_n),
		.config_done_flag_i(done_wire), .config_done_flag_o(done_o),
		.config_done_flag_oe(done_oe), .user_mode(user_mode), .reload_start(reload_start),
		.tck(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
	cct_host host (.done_o(done_o), .done_oe(done_oe), .hold_low(hold_low), .tdo_o(tdo_o),
		.tdo_oe(tdo_oe), .done_wire(done_wire), .tck(tck), .tms(tms), .tdi(tdi));
	task automatic close_out();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wait_user(input logic lvl);
		for (int i = 0; i < 80 && user_mode !== lvl; i++) @(negedge clk_sys);
		if (user_mode !== lvl) begin
			check("user_mode wait", user_mode, lvl);
			close_out();
		end
	endtask : wait_user
	// Walk tms bits, first bit lowest
	task automatic moves(input logic [7:0] m, input int k);
		for (int i = 0; i < k; i++) host.step(m[i], 1'b1, 1'b1, b, oe);
	endtask : moves
	task automatic shift(input logic [7:0] d, input int k);
		q = 8'h00;
		for (int i = 0; i < k; i++) begin
			host.step(i == k - 1, d[i], 1'b1, b, oe);
			q[i] = b;
			check("tdo_oe shifting", oe, 8'h01);
		end
		moves(8'h01, 2);
	endtask : shift
	task automatic ir(input logic [7:0] code);
		moves(8'h03, 4);
		shift(code, 4);
		check("ir capture", q, {4'h0, IR_CAPTURE});
	endtask : ir
	task automatic dr(input logic [7:0] d, input int k);
		moves(8'h01, 3);
		shift(d, k);
	endtask : dr
	task automatic t_tap();
		repeat (5) host.step(1'b0, 1'b0, 1'b0, b, oe);
		host.step(1'b0, 1'b0, 1'b1, b, oe);
		check("tdo_oe idle", oe, 8'h00);
		ir({4'h0, IR_STATUS});
		dr(8'h00, 2);
		check("status user", q, 8'h02);
		ir({4'h0, IR_BYPASS});
		dr(8'h0d, 5);
		check("bypass delay", q >> 1, 8'h0d);
	endtask : t_tap
	task automatic t_hold();
		@(posedge clk_sys) hold_low <= 1'b1;
		wait_user(1'b0);
		repeat (20) @(negedge clk_sys);
		check("user held off", user_mode, 8'h00);
		@(posedge clk_sys) hold_low <= 1'b0;
		wait_user(1'b1);
	endtask : t_hold
	task automatic t_creset();
		ir({4'h0, IR_STATUS});
		n = 0;
		@(posedge clk_sys) creset_req_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		creset_req_n <= 1'b1;
		repeat (12) @(negedge clk_sys) n += reload_start;
		check("short pulse", n[7:0], 8'h00);
		@(posedge clk_sys) creset_req_n <= 1'b0;
		repeat (6) @(negedge clk_sys) n += reload_start;
		check("start while low", n[7:0], 8'h00);
		@(posedge clk_sys) creset_req_n <= 1'b1;
		repeat (8) @(negedge clk_sys) n += reload_start;
		check("long pulse start", n[7:0], 8'h01);
		check("done reloading", done_wire, 8'h00);
		check("user left", user_mode, 8'h00);
		dr(8'h00, 2);
		check("status loading", q, 8'h01);
		wait_user(1'b1);
	endtask : t_creset
	initial begin
		repeat (2) host.step(1'b0, 1'b0, 1'b0, b, oe);
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		@(negedge clk_sys);
		check("done in load", done_oe, 8'h01);
		check("user in load", user_mode, 8'h00);
		wait_user(1'b1);
		check("done released", done_wire, 8'h01);
		// Board holds its side off for the user settle time
		repeat (USER_HOLD_CYC) @(negedge clk_sys);
		check("user after hold", user_mode, 8'h01);
		t_tap();
		t_hold();
		t_creset();
		close_out();
	end
endmodule : tb
